// file: hdl/pwla_cfg.svh
`ifndef PWLA_CFG_SVH
`define PWLA_CFG_SVH

// Width register limits and widths
`define PWLA_WIDTH_MAX 9'h1FF
`define PWLA_LIMIT_TOP 8'hFF
`define PWLA_ITMR_TOP 8'hFF

// Reverse step interval unit in system clocks
`define PWLA_REV_UNIT_CYC 7'h10

// Index of each width register in the write bundle
`define PWLA_IDX_A 0
`define PWLA_IDX_B 1
`define PWLA_IDX_C 2
`define PWLA_IDX_D 3

// Change mode encodings for trigger count and step value
`define PWLA_CHG_KEEP 2'h0
`define PWLA_CHG_DEC 2'h1
`define PWLA_CHG_INC 2'h2
`define PWLA_CHG_LOAD 2'h3

`endif

// file: hdl/pwla_core.sv
// Overview of operation
// (RL1) Primary limit timer runs trigger to overflow/stop
// (RL2) Primary output off after 256 minus limit
// (RL3) Secondary timer halts on overflow or stops
// (RL4) Limit timers reload on overflow and trigger
// (RL5) Load select chooses register A or B
// (RL6) Enabled comparator falling edge sets load select
// (RL7) Comparator 1 fall adds reverse step to A
// (RL8) Comparator low: step again each interval
// (RL9) Stepping ends at 1FF or comparator high
// (RL10) Approach only while comparator 1 high
// (RL11) Software mode when select is zero
// (RL12) Approach enable also sets in-progress flag
// (RL13) Software leaves A and fields during approach; software A writes still take effect then, ahead of approach steps
// (RL14) Reached flags clear until A equals target
// (RL15) A steps toward target per trigger count
// (RL16) After adjust interval, change count and step
// (RL17) Interval timer reloads and counts while running
// (RL18) Interval timer overflow raises interrupt pulse
// (RL19) Software writes extension before low byte
// (RL20) Reached interrupt needs all three enables
// (RL21) Target select 0 picks C, 1 D
// (RL22) Reached flags clear by software, never set
// (RL23) Low write merges stored extension bit
// (RL24) Reverse stepping saturates at 9-bit maximum
`timescale 1ns/10ps
`default_nettype none
`include "pwla_cfg.svh"

module pwla_core import pwla_pkg::*; (
  input wire logic mclk_in,                    // 40 MHz system clock
  input wire logic rst_n_in,                   // Synchronous reset, active low
  input wire pwla_wr_s width_wr_in,            // Width register writes
  input wire pwla_appr_cfg_s appr_cfg_in,      // Approach configuration
  input wire logic pg_trigger_in,              // Generator trigger pulse
  input wire logic pg_stop_in,                 // Generator stop pulse
  input wire logic sec_trigger_in,             // Secondary trigger pulse
  input wire logic sec_stop_in,                // Secondary stop pulse
  input wire logic primary_drive_in,           // Raw primary gate drive
  input wire logic secondary_drive_in,         // Raw secondary gate drive
  input wire logic [7:0] primary_width_limit_value_in,   // Primary limit
  input wire logic [7:0] secondary_width_limit_value_in, // Secondary limit
  input wire logic load_sel_wr_in,             // Software load select write
  input wire logic load_sel_data_in,           // Load select write data
  input wire logic [2:0] comparator_trip_output_in,     // Comparators 1, 3, 5
  input wire logic [2:0] comparator_reload_enable_in,   // Reload enables 1, 3, 5
  input wire logic [1:0] reverse_step_interval_in,      // Step interval select
  input wire logic [3:0] reverse_step_value_in,         // Reverse step size
  input wire logic reached_c_clr_in,           // Software clear of C flag
  input wire logic reached_d_clr_in,           // Software clear of D flag
  input wire logic global_interrupt_enable_in, // Global enable
  input wire logic approach_reached_int_enable_in, // Reached enable
  input wire logic multi_function_enable_in,   // Multi-function enable
  input wire logic [7:0] interval_reload_one_in, // Interval timer reload
  input wire logic interval_timer_run_in,      // Interval timer run
  output logic primary_pulse_output_out,       // Gated primary drive
  output logic secondary_pulse_output_out,     // Gated secondary drive
  output logic load_select_bit_out,            // Load source select
  output logic [8:0] load_value_out,           // Counter load value
  output logic [8:0] width_register_a_out,     // Width register A
  output logic approach_in_progress_flag_out,  // Approach running
  output logic reached_c_flag_out,             // A reached C
  output logic reached_d_flag_out,             // A reached D
  output logic reverse_active_out,             // Reverse stepping active
  output logic approach_reached_interrupt_out, // Reached interrupt
  output logic interval_timer_interrupt_out    // Interval overflow pulse
);

  logic [8:0] width_ff [4];
  logic ext_ff;
  logic half_ff;
  logic pri_exp, sec_exp;
  logic pri_out_ff, sec_out_ff;
  logic [2:0] comp_prev_ff;
  logic [2:0] comp_fall;
  logic load_sel_ff;
  logic [8:0] load_value_ff;
  pwla_adj_e st_ff, nxt_st;
  logic [6:0] rev_cnt_ff, rev_len;
  logic [9:0] rev_sum;
  logic [8:0] sat_rev;
  logic rev_step;
  logic en_prev_ff, appr_start, inprog_ff, appr_go;
  logic [8:0] target;
  logic at_target;
  logic [1:0] trig_cnt_ff, eff_cnt_ff;
  logic [2:0] adj_cnt_ff, eff_step_ff;
  logic appr_step;
  logic [3:0] step_size;
  logic [8:0] appr_next;
  logic reached_c_ff, reached_d_ff;
  logic [7:0] itmr_ff;
  logic run_prev_ff, itmr_on, itmr_ovf, itmr_int_ff;
  logic [8:0] nxt_a;
  logic comp1;

  assign comp1 = comparator_trip_output_in[0];
  assign comp_fall = comp_prev_ff & ~comparator_trip_output_in;

  // Half generator rate enable for the limit timers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) half_ff <= 1'b0;
    else half_ff <= ~half_ff;
  end

  // (RL1) primary limit timer
  pwla_limit_timer u_pri_limit (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .half_tick_in(half_ff),
    .start_in(pg_trigger_in), .reload_in(1'b0), .halt_in(pg_stop_in),
    .limit_in(primary_width_limit_value_in), .expired_out(pri_exp));

  // (RL3) secondary limit timer, also halted by primary stop
  pwla_limit_timer u_sec_limit (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .half_tick_in(half_ff),
    .start_in(sec_trigger_in), .reload_in(pg_trigger_in), .halt_in(sec_stop_in || pg_stop_in),
    .limit_in(secondary_width_limit_value_in), .expired_out(sec_exp));

  // (RL2) force outputs off after limit expiry
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pri_out_ff <= 1'b0;
      sec_out_ff <= 1'b0;
    end else begin
      pri_out_ff <= primary_drive_in && !pri_exp;
      sec_out_ff <= secondary_drive_in && !sec_exp;
    end
  end

  // Comparator history for edge detection
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) comp_prev_ff <= 3'h7;
    else comp_prev_ff <= comparator_trip_output_in;
  end

  // Load select bit, hardware set wins over software write
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      load_sel_ff <= 1'b0;
    // (RL6) enabled falling edge selects B
    end else if (|(comp_fall & comparator_reload_enable_in)) begin
      load_sel_ff <= 1'b1;
    end else if (load_sel_wr_in) begin
      load_sel_ff <= load_sel_data_in;
    end
  end

  // (RL5) counter load source
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) load_value_ff <= 9'h000;
    else load_value_ff <= load_sel_ff ? width_ff[`PWLA_IDX_B] : width_ff[`PWLA_IDX_A];
  end

  // (RL23) extension bit held for the next low byte write
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) ext_ff <= 1'b0;
    else if (width_wr_in.ext_wr) ext_ff <= width_wr_in.ext_bit;
  end

  // Registers B to D take software writes only
  genvar gi;
  generate
    for (gi = 1; gi < 4; gi++) begin : g_wreg
      always_ff @(posedge mclk_in) begin
        if (!rst_n_in) width_ff[gi] <= 9'h000;
        // (RL23) merge extension with low byte
        else if (width_wr_in.low_wr[gi]) width_ff[gi] <= {ext_ff, width_wr_in.low_data};
      end
    end
  endgenerate

  // (RL24) saturating reverse increment
  assign rev_sum = {1'b0, width_ff[`PWLA_IDX_A]} + {6'h00, reverse_step_value_in};
  assign sat_rev = rev_sum[9] ? `PWLA_WIDTH_MAX : rev_sum[8:0];
  assign rev_len = (reverse_step_interval_in == 2'h0) ? `PWLA_REV_UNIT_CYC : {reverse_step_interval_in, 5'h00} >> 1;
  // (RL8) repeat step when the interval elapses
  assign rev_step = (st_ff == PWLA_ST_REV) && !comp1 && (rev_cnt_ff == rev_len - 7'h01)
    && (width_ff[`PWLA_IDX_A] != `PWLA_WIDTH_MAX);

  // (RL11) software mode only; (RL10) comparator must be high
  assign appr_start = appr_cfg_in.enable && !en_prev_ff && !appr_cfg_in.mode_sel;
  assign appr_go = inprog_ff && appr_cfg_in.enable && !appr_cfg_in.mode_sel && comp1;
  // (RL21) target select
  assign target = appr_cfg_in.target_sel ? width_ff[`PWLA_IDX_D] : width_ff[`PWLA_IDX_C];
  assign at_target = width_ff[`PWLA_IDX_A] == target;
  // (RL15) one step per configured number of triggers
  assign appr_step = (st_ff == PWLA_ST_APPR) && comp1 && pg_trigger_in && (trig_cnt_ff == eff_cnt_ff) && !at_target;
  assign step_size = {1'b0, eff_step_ff} + 4'h1;

  // Move A toward the target without passing it
  always_comb begin
    appr_next = width_ff[`PWLA_IDX_A];
    if (width_ff[`PWLA_IDX_A] < target) begin
      appr_next = (target - width_ff[`PWLA_IDX_A] <= {5'h00, step_size}) ? target
        : width_ff[`PWLA_IDX_A] + {5'h00, step_size};
    end else if (width_ff[`PWLA_IDX_A] > target) begin
      appr_next = (width_ff[`PWLA_IDX_A] - target <= {5'h00, step_size}) ? target
        : width_ff[`PWLA_IDX_A] - {5'h00, step_size};
    end
  end

  // Adjustment state transitions
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      PWLA_ST_IDLE: begin
        if (comp_fall[0]) nxt_st = PWLA_ST_REV;
        else if (appr_go) nxt_st = PWLA_ST_APPR;
      end
      PWLA_ST_APPR: begin
        // (RL10) drop into reverse stepping at once
        if (!comp1) nxt_st = PWLA_ST_REV;
        else if (!appr_go || at_target) nxt_st = PWLA_ST_IDLE;
      end
      PWLA_ST_REV: begin
        // (RL9) stop at maximum or comparator high
        if (comp1 || width_ff[`PWLA_IDX_A] == `PWLA_WIDTH_MAX) nxt_st = PWLA_ST_IDLE;
      end
      default: nxt_st = PWLA_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) st_ff <= PWLA_ST_IDLE;
    else st_ff <= nxt_st;
  end

  // Reverse interval counter, disabled outside stepping
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) rev_cnt_ff <= 7'h00;
    // (RL7) start interval on falling edge
    else if (comp_fall[0] || rev_step || st_ff != PWLA_ST_REV) rev_cnt_ff <= 7'h00;
    else rev_cnt_ff <= rev_cnt_ff + 7'h01;
  end

  // Next value of width register A
  always_comb begin
    nxt_a = width_ff[`PWLA_IDX_A];
    if (width_wr_in.low_wr[`PWLA_IDX_A]) nxt_a = {ext_ff, width_wr_in.low_data};
    // (RL7) first reverse step on the falling edge
    else if (comp_fall[0] || rev_step) nxt_a = sat_rev;
    else if (appr_step) nxt_a = appr_next;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) width_ff[`PWLA_IDX_A] <= 9'h000;
    else width_ff[`PWLA_IDX_A] <= nxt_a;
  end

  // Approach in-progress flag
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      en_prev_ff <= 1'b0;
      inprog_ff <= 1'b0;
    end else begin
      en_prev_ff <= appr_cfg_in.enable;
      // (RL12) set when software enables approach
      if (appr_start) inprog_ff <= 1'b1;
      else if (!appr_cfg_in.enable || appr_cfg_in.mode_sel || (st_ff == PWLA_ST_APPR && at_target)) inprog_ff <= 1'b0;
    end
  end

  // Trigger and adjustment counters with effective count and step
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      trig_cnt_ff <= 2'h0;
      adj_cnt_ff <= 3'h0;
      eff_cnt_ff <= 2'h0;
      eff_step_ff <= 3'h0;
    end else if (appr_start) begin
      trig_cnt_ff <= 2'h0;
      adj_cnt_ff <= 3'h0;
      eff_cnt_ff <= appr_cfg_in.trig_count;
      eff_step_ff <= appr_cfg_in.step;
    end else if (appr_step) begin
      trig_cnt_ff <= 2'h0;
      adj_cnt_ff <= adj_cnt_ff + 3'h1;
      // (RL16) change count and step after the interval
      if (adj_cnt_ff == appr_cfg_in.adj_times) begin
        adj_cnt_ff <= 3'h0;
        case (appr_cfg_in.cnt_chg)
          `PWLA_CHG_DEC: if (eff_cnt_ff != 2'h0) eff_cnt_ff <= eff_cnt_ff - 2'h1;
          `PWLA_CHG_INC: if (eff_cnt_ff != 2'h3) eff_cnt_ff <= eff_cnt_ff + 2'h1;
          `PWLA_CHG_LOAD: eff_cnt_ff <= appr_cfg_in.trig_count;
          default: eff_cnt_ff <= eff_cnt_ff;
        endcase
        case (appr_cfg_in.step_chg)
          `PWLA_CHG_DEC: if (eff_step_ff != 3'h0) eff_step_ff <= eff_step_ff - 3'h1;
          `PWLA_CHG_INC: if (eff_step_ff != 3'h7) eff_step_ff <= eff_step_ff + 3'h1;
          `PWLA_CHG_LOAD: eff_step_ff <= appr_cfg_in.step;
          default: eff_step_ff <= eff_step_ff;
        endcase
      end
    end else if (st_ff == PWLA_ST_APPR && comp1 && pg_trigger_in) begin
      trig_cnt_ff <= trig_cnt_ff + 2'h1;
    end
  end

  // Reached flags: hardware set wins over software clear
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reached_c_ff <= 1'b0;
      reached_d_ff <= 1'b0;
    // (RL14) set on equality, held clear before
    end else if (st_ff == PWLA_ST_APPR && comp1 && at_target) begin
      reached_c_ff <= !appr_cfg_in.target_sel;
      reached_d_ff <= appr_cfg_in.target_sel;
    end else if (appr_start || inprog_ff) begin
      reached_c_ff <= 1'b0;
      reached_d_ff <= 1'b0;
    end else begin
      // (RL22) software may only clear
      if (reached_c_clr_in) reached_c_ff <= 1'b0;
      if (reached_d_clr_in) reached_d_ff <= 1'b0;
    end
  end

  // (RL17) interval timer as a general timer in software mode
  assign itmr_on = interval_timer_run_in && !appr_cfg_in.mode_sel;
  assign itmr_ovf = itmr_on && run_prev_ff && (itmr_ff == `PWLA_ITMR_TOP);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      itmr_ff <= 8'h00;
      run_prev_ff <= 1'b0;
      itmr_int_ff <= 1'b0;
    end else begin
      run_prev_ff <= itmr_on;
      // (RL18) overflow pulse
      itmr_int_ff <= itmr_ovf;
      if (!itmr_on || !run_prev_ff || itmr_ovf) itmr_ff <= interval_reload_one_in;
      else itmr_ff <= itmr_ff + 8'h01;
    end
  end

  // (RL20) reached interrupt gated by all three enables
  assign approach_reached_interrupt_out = (reached_c_ff || reached_d_ff) && global_interrupt_enable_in
    && approach_reached_int_enable_in && multi_function_enable_in;

  assign primary_pulse_output_out = pri_out_ff;
  assign secondary_pulse_output_out = sec_out_ff;
  assign load_select_bit_out = load_sel_ff;
  assign load_value_out = load_value_ff;
  assign width_register_a_out = width_ff[`PWLA_IDX_A];
  assign approach_in_progress_flag_out = inprog_ff;
  assign reached_c_flag_out = reached_c_ff;
  assign reached_d_flag_out = reached_d_ff;
  assign reverse_active_out = (st_ff == PWLA_ST_REV);
  assign interval_timer_interrupt_out = itmr_int_ff;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rev_entry;
    comp_fall[0] && !width_wr_in.low_wr[0];
  endsequence

  chk_rev_first_step: assert property (s_rev_entry |=> width_ff[0] == $past(sat_rev) && st_ff == PWLA_ST_REV) // (RL7)
    else $error("reverse step missing on comparator fall");
  chk_rev_stop_high: assert property (st_ff == PWLA_ST_REV && comp1 |=> st_ff != PWLA_ST_REV) // (RL9)
    else $error("reverse stepping did not stop");
  chk_appr_to_rev: assert property (st_ff == PWLA_ST_APPR && !comp1 |=> st_ff == PWLA_ST_REV) // (RL10)
    else $error("approach did not yield to reverse stepping");
  chk_load_sel_edge: assert property (|(comp_fall & comparator_reload_enable_in) |=> load_sel_ff ##1 load_value_ff == $past(width_ff[1])) // (RL6)
    else $error("load select not set by comparator edge");
  chk_appr_flag_set: assert property (appr_start |=> inprog_ff && !reached_c_ff && !reached_d_ff) // (RL12)
    else $error("in-progress flag not set on enable");
  chk_reached_cause: assert property ($rose(reached_c_ff) |-> $past(at_target && !appr_cfg_in.target_sel && st_ff == PWLA_ST_APPR)) // (RL22)
    else $error("reached flag set without equality");
  chk_itmr_pulse: assert property (itmr_ovf |=> itmr_int_ff && itmr_ff == $past(interval_reload_one_in)) // (RL18)
    else $error("interval overflow did not raise interrupt");
  chk_reached_int: assert property (approach_reached_interrupt_out |-> (reached_c_ff || reached_d_ff) && global_interrupt_enable_in) // (RL20)
    else $error("reached interrupt without flag or enable");

endmodule

`default_nettype wire

// file: hdl/pwla_limit_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwla_cfg.svh"

module pwla_limit_timer import pwla_pkg::*; (
  input wire logic mclk_in,         // System clock
  input wire logic rst_n_in,        // Synchronous reset, active low
  input wire logic half_tick_in,    // Half generator rate enable
  input wire logic start_in,        // Trigger: load and run
  input wire logic reload_in,       // Reload without starting
  input wire logic halt_in,         // Stop counting
  input wire logic [7:0] limit_in,  // Limit register value
  output logic expired_out          // Width limit reached
);

  logic [7:0] cnt_ff;
  logic run_ff;
  logic expired_ff;
  logic ovf;

  assign ovf = run_ff && half_tick_in && (cnt_ff == `PWLA_LIMIT_TOP);
  assign expired_out = expired_ff;

  // Counter from limit value up to overflow
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 8'h00;
    // (RL4) reload on trigger
    end else if (start_in || reload_in || ovf) begin
      cnt_ff <= limit_in;
    end else if (run_ff && half_tick_in) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Run control
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      run_ff <= 1'b0;
    // (RL1) start on trigger
    end else if (start_in) begin
      run_ff <= 1'b1;
    // (RL3) halt on stops
    end else if (halt_in || ovf) begin
      run_ff <= 1'b0;
    end
  end

  // Expiry flag, cleared by the next trigger
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      expired_ff <= 1'b0;
    end else if (start_in) begin
      expired_ff <= 1'b0;
    // (RL2) limit reached
    end else if (ovf) begin
      expired_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_limit_expire: assert property (ovf && !start_in |=> expired_ff && !run_ff) // (RL2)
    else $error("limit timer did not expire on overflow");
  chk_limit_halt: assert property (halt_in && !start_in |=> !run_ff ##1 !$rose(expired_ff)) // (RL1)
    else $error("limit timer kept running after halt");
  chk_limit_reload: assert property (start_in |=> run_ff && cnt_ff == $past(limit_in) && !expired_ff) // (RL4)
    else $error("limit timer not reloaded on trigger");

endmodule

`default_nettype wire

// file: hdl/pwla_pkg.sv
package pwla_pkg;

  // Software write bundle for the four 9-bit width registers
  typedef struct packed {
    logic ext_wr;         // High byte extension write strobe
    logic ext_bit;        // Extension bit data
    logic [3:0] low_wr;   // Low byte write strobes, A..D
    logic [7:0] low_data; // Low byte data
  } pwla_wr_s;

  // Approach configuration fields
  typedef struct packed {
    logic mode_sel;         // 0 selects software approach mode
    logic enable;           // Approach enable
    logic target_sel;       // 0 targets C, 1 targets D
    logic [1:0] trig_count; // Triggers per adjustment minus one
    logic [2:0] step;       // Step value minus one
    logic [2:0] adj_times;  // Adjustments per change minus one
    logic [1:0] cnt_chg;    // Trigger count change mode
    logic [1:0] step_chg;   // Step value change mode
  } pwla_appr_cfg_s;

  // Width register A adjustment state
  typedef enum logic [2:0] {
    PWLA_ST_IDLE = 3'b001,
    PWLA_ST_REV = 3'b010,
    PWLA_ST_APPR = 3'b100
  } pwla_adj_e;

endpackage

// file: testbench/pwla_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// Comparator trips and raw gate drive levels at the far side of the block
module pwla_far_model (
  input wire logic mclk_in,                      // System clock
  input wire logic [2:0] trip_cmd_in,            // Wanted comparator levels
  input wire logic [1:0] drive_cmd_in,           // Wanted drive levels
  output logic [2:0] comparator_trip_output_out, // Comparators 1, 3, 5
  output logic [1:0] gate_drive_out              // Primary, secondary drive
);
  // Levels move on the edge, as trips re-timed on chip would
  always_ff @(posedge mclk_in) begin
    comparator_trip_output_out <= trip_cmd_in;
    gate_drive_out <= drive_cmd_in;
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import pwla_pkg::*;;
  logic mclk, rst_n, pg_t, pg_s, s_t, s_s, lsw, lsd, cclr, dclr, gie, rie, mfe, run;
  logic p_out, s_out, lsb, in_prog, rc, rd, rev, rint, tint;
  logic [2:0] trip, ren;
  logic [1:0] drv, rsi;
  logic [3:0] rsv;
  logic [7:0] plim, slim, rld;
  logic [8:0] lval, wa, n;
  wire logic [2:0] comps;
  wire logic [1:0] gdrv;
  pwla_wr_s wr;
  pwla_appr_cfg_s cfg;
  int n_errors, total_checks, i;
  pwla_far_model pwla_far_model_inst (.mclk_in(mclk), .trip_cmd_in(trip), .drive_cmd_in(drv),
    .comparator_trip_output_out(comps), .gate_drive_out(gdrv));
  pwla_core pwla_core_inst (.mclk_in(mclk), .rst_n_in(rst_n), .width_wr_in(wr), .appr_cfg_in(cfg),
    .pg_trigger_in(pg_t), .pg_stop_in(pg_s), .sec_trigger_in(s_t), .sec_stop_in(s_s),
    .primary_drive_in(gdrv[0]), .secondary_drive_in(gdrv[1]),
    .primary_width_limit_value_in(plim), .secondary_width_limit_value_in(slim),
    .load_sel_wr_in(lsw), .load_sel_data_in(lsd), .comparator_trip_output_in(comps),
    .comparator_reload_enable_in(ren), .reverse_step_interval_in(rsi), .reverse_step_value_in(rsv),
    .reached_c_clr_in(cclr), .reached_d_clr_in(dclr), .global_interrupt_enable_in(gie),
    .approach_reached_int_enable_in(rie), .multi_function_enable_in(mfe),
    .interval_reload_one_in(rld), .interval_timer_run_in(run),
    .primary_pulse_output_out(p_out), .secondary_pulse_output_out(s_out),
    .load_select_bit_out(lsb), .load_value_out(lval), .width_register_a_out(wa),
    .approach_in_progress_flag_out(in_prog), .reached_c_flag_out(rc), .reached_d_flag_out(rd),
    .reverse_active_out(rev), .approach_reached_interrupt_out(rint),
    .interval_timer_interrupt_out(tint));
  // 40 MHz clock
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tk(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic chk(input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // extension byte first, then the low byte of register idx
  task automatic wreg(input int idx, input logic [8:0] v);
    wr.ext_wr = 1;
    wr.ext_bit = v[8];
    tk(1);
    wr.ext_wr = 0;
    wr.low_wr[idx] = 1;
    wr.low_data = v[7:0];
    tk(1);
    wr.low_wr = 4'h0;
  endtask
  task automatic pg_pulse();
    pg_t = 1;
    tk(1);
    pg_t = 0;
    tk(2);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (8000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    {rst_n, pg_t, pg_s, s_t, s_s, lsw, lsd, cclr, dclr, run, rsi, rsv, ren, plim, slim} = '0;
    {gie, rie, mfe, trip, drv, rld} = {3'h7, 3'h7, 2'h0, 8'h00};
    wr = '0;
    cfg = '0;
    tk(20);
    rst_n = 1;
    tk(1);
    // Write path and load source choice
    wreg(0, 9'h100); chk(9'h100, wa);
    tk(2); chk(9'h100, lval);
    wreg(1, 9'h055); lsw = 1; lsd = 1; tk(1); lsw = 0; tk(2); chk(9'h055, lval);
    lsw = 1; lsd = 0; tk(1); lsw = 0; tk(2); chk(9'h000, lsb);
    // Only the enabled comparator edge switches the source
    ren = 3'h4; trip[1] = 0; tk(4); chk(9'h000, lsb);
    trip[2] = 0; tk(4); chk(9'h001, lsb);
    trip = 3'h7; ren = 3'h0; lsw = 1; tk(1); lsw = 0;
    // Reverse stepping, 16-cycle interval, step 8
    wreg(0, 9'h100); rsi = 2'h1; rsv = 4'h8; trip[0] = 0;
    tk(8); chk(9'h108, wa);
    tk(16); chk(9'h110, wa);
    tk(16); chk(9'h118, wa); trip[0] = 1; tk(4); chk(9'h000, rev);
    tk(40); chk(9'h118, wa);
    wreg(0, 9'h1FC); trip[0] = 0; tk(8); chk(9'h1FF, wa);
    chk(9'h000, rev); trip[0] = 1; tk(3);
    // Width limits: 32 cycles primary, 16 secondary
    plim = 8'hF0; slim = 8'hF8; drv = 2'h3; tk(3);
    pg_pulse(); tk(8); chk(9'h001, p_out); tk(30); chk(9'h000, p_out);
    s_t = 1; tk(1); s_t = 0; tk(8); chk(9'h001, s_out); tk(14); chk(9'h000, s_out);
    pg_pulse(); tk(3); pg_s = 1; tk(1); pg_s = 0; tk(40); chk(9'h001, p_out);
    drv = 2'h0;
    // A and step fields untouched while approaching
    // Approach A toward C in steps of 4, one trigger each
    wreg(2, 9'h10C); wreg(3, 9'h0F0); wreg(0, 9'h100);
    cfg.step = 3'h3; cfg.adj_times = 3'h7; cfg.enable = 1; tk(2); chk(9'h001, in_prog);
    pg_pulse(); pg_pulse(); chk(9'h108, wa); chk(9'h000, rc);
    pg_pulse(); chk(9'h10C, wa); chk(9'h001, rc); chk(9'h001, rint);
    rie = 0; tk(1); chk(9'h000, rint);
    cclr = 1; tk(1); cclr = 0; tk(2); chk(9'h000, rc);
    // Toward D with the step growing by one after every step
    cfg.enable = 0; tk(2);
    cfg = '{mode_sel: 0, enable: 1, target_sel: 1, trig_count: 0, step: 0, adj_times: 0, cnt_chg: 0, step_chg: 2};
    tk(2);
    repeat (7) pg_pulse();
    chk(9'h0F0, wa); chk(9'h001, rd);
    dclr = 1; tk(1); dclr = 0; tk(2); chk(9'h000, rd);
    // Comparator 1 low during approach hands over to reverse stepping
    cfg.enable = 0; tk(2); cfg.target_sel = 0; cfg.enable = 1; tk(2);
    trip[0] = 0; tk(4); chk(9'h001, rev); trip[0] = 1; cfg.enable = 0; tk(4);
    // Hardware approach selected: enabling must not start a software approach
    cfg.mode_sel = 1; cfg.enable = 1; tk(2); chk(9'h000, in_prog);
    cfg = '0; tk(2);
    // Interval timer period 256-0xF0
    rld = 8'hF0; run = 1; i = 0;
    while (tint !== 1'b1 && i < 600) begin tk(1); i++; end
    n = 0; tk(1);
    while (tint !== 1'b1 && n < 300) begin tk(1); n++; end
    chk(9'h00F, n);
    wrap_up();
  end
endmodule
`default_nettype wire
